// ---- rtl/ticb_top.sv ----
// Telemetry and identity command bank behind a two-wire command link.
// Assumes samples arrive on clk with a strobe and the stored identity comes from NVM.
//
// How it works
// - Write to read-only command sets fault summary.
// - Same fault also sets invalid-command flag bit7.
// - Recorded fault pulls the alert line low.
// - Command 8Ch is read-only word current.
// - Words: exponent 15:11, mantissa 10:0, signed.
// - Phase FFh reads summed stack current.
// - Other phase reads current of the phase its bit 0 picks.
// - Per-phase current kept between -15 A, 90 A.
// - Command 8Dh is read-only word temperature.
// - Temperature uses linear words, one degree LSB.
// - Phase FFh reads hottest stage temperature.
// - Other phase reads temperature of the phase its bit 0 picks.
// - Command 98h reads compliance nibbles, read-only.
// - Command 99h block write and block read.
// - Identity bits 23:0 start from saved NVM.
// - Writing one clears a status bit.
`timescale 1ns/1ns
`default_nettype none
module ticb_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic alert_out,
  output logic alert_oe_n,
  input wire logic sample_strobe,
  input wire logic [ticb_pkg::MAN_W-1:0] phase0_current,
  input wire logic [ticb_pkg::MAN_W-1:0] phase1_current,
  input wire logic [ticb_pkg::MAN_W-1:0] phase0_temperature,
  input wire logic [ticb_pkg::MAN_W-1:0] phase1_temperature,
  input wire logic [ticb_pkg::ID_W-1:0] nvm_id_value,
  output logic nvm_save,
  output logic [ticb_pkg::ID_W-1:0] nvm_save_data
);
  import ticb_pkg::*;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // Scales a wide signed sum into a linear word, raising the exponent.
  function automatic logic [15:0] lin_word(input logic signed [12:0] v,
                                           input logic [EXP_W-1:0] e);
    logic signed [12:0] m;
    logic [EXP_W-1:0] x;
    m = v;
    x = e;
    for (int i = 0; i < 2; i++) begin
      if (m > 13'sh03FF || m < -13'sh0400) begin
        m = m >>> 1;
        x = x + 5'h01;
      end
    end
    lin_word = {x, m[MAN_W-1:0]};
  endfunction : lin_word

  // Picks byte idx of a response, padding past its length.
  function automatic logic [7:0] pick_byte(input logic [31:0] buff,
                                           input logic [2:0] len,
                                           input logic [2:0] idx);
    pick_byte = (idx < len) ? buff[{idx[1:0], 3'b000} +: 8] : FILL_BYTE;
  endfunction : pick_byte

  // ----------------------------------------------------------------------
  // Link domain: synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic link_rst_n;
  logic scl_s;
  logic sda_s;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  ticb_sync u_link_rst (.clk(link_clk), .rst_n(1'b1), .d(rst_n), .q(link_rst_n));
  ticb_sync #(.RESET_VAL(1'b1)) u_scl (.clk(link_clk), .rst_n(link_rst_n), .d(scl_in),
                                        .q(scl_s));
  ticb_sync #(.RESET_VAL(1'b1)) u_sda (.clk(link_clk), .rst_n(link_rst_n), .d(sda_in),
                                        .q(sda_s));

  // Previous pin levels, taken only from the synchronised copies.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop = scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------------------------------------
  // Link domain: byte engine
  // ----------------------------------------------------------------------
  ticb_link_state_t link_state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic addr_phase;
  logic rd_mode;
  logic have_cmd;
  logic tx_acked;
  logic [7:0] cmd_reg;
  logic [31:0] wr_buf;
  logic [2:0] wr_cnt;
  logic [31:0] rsp_buf;
  logic [2:0] rsp_len;
  logic [2:0] rsp_idx;
  logic sda_low;
  logic scl_low;
  logic req_fire;
  logic [REQ_W-1:0] req_data;
  logic req_ready;
  logic rsp_valid;
  logic [RSP_W-1:0] rsp_word;
  logic [7:0] first_byte;
  logic [7:0] next_byte;

  assign first_byte = pick_byte(rsp_word[31:0], rsp_word[34:32], 3'h0);
  assign next_byte = pick_byte(rsp_buf, rsp_len, rsp_idx);

  // Frames are start, address, command, then data in or, after a repeated
  // start, data out. The clock is held low while the core builds an answer,
  // so a read waits out the crossing latency before its first data bit.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      link_state <= LINK_IDLE;
      bit_cnt <= 4'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      addr_phase <= 1'b0;
      rd_mode <= 1'b0;
      have_cmd <= 1'b0;
      tx_acked <= 1'b0;
      cmd_reg <= 8'h00;
      wr_buf <= 32'h00000000;
      wr_cnt <= 3'h0;
      rsp_buf <= 32'h00000000;
      rsp_len <= 3'h0;
      rsp_idx <= 3'h0;
      sda_low <= 1'b0;
      scl_low <= 1'b0;
      req_fire <= 1'b0;
      req_data <= '0;
    end else begin
      req_fire <= 1'b0;
      if (bus_stop) begin
        // A finished write frame goes to the core as one request.
        if (link_state != LINK_IDLE && have_cmd && !rd_mode && req_ready) begin
          req_fire <= 1'b1;
          req_data <= {1'b0, cmd_reg, wr_cnt, wr_buf};
        end
        link_state <= LINK_IDLE;
        sda_low <= 1'b0;
        scl_low <= 1'b0;
        have_cmd <= 1'b0;
      end else if (bus_start) begin
        if (link_state == LINK_IDLE) begin
          have_cmd <= 1'b0;
        end
        link_state <= LINK_RX;
        bit_cnt <= 4'h0;
        addr_phase <= 1'b1;
        sda_low <= 1'b0;
        scl_low <= 1'b0;
      end else begin
        case (link_state)
          LINK_RX: begin
            if (scl_rise) begin
              rx_sh <= {rx_sh[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
              if (addr_phase) begin
                if (rx_sh[7:1] == BUS_ADDRESS) begin
                  sda_low <= 1'b1;
                  rd_mode <= rx_sh[0];
                  addr_phase <= 1'b0;
                  link_state <= LINK_RX_ACK;
                end else begin
                  link_state <= LINK_IDLE;
                end
              end else begin
                if (!have_cmd) begin
                  cmd_reg <= rx_sh;
                  have_cmd <= 1'b1;
                  wr_cnt <= 3'h0;
                end else if (wr_cnt < MAX_WRITE_BYTES) begin
                  wr_buf[{wr_cnt[1:0], 3'b000} +: 8] <= rx_sh;
                  wr_cnt <= wr_cnt + 3'h1;
                end
                sda_low <= 1'b1;
                link_state <= LINK_RX_ACK;
              end
            end
          end
          LINK_RX_ACK: begin
            if (scl_fall) begin
              sda_low <= 1'b0;
              bit_cnt <= 4'h0;
              if (!rd_mode) begin
                link_state <= LINK_RX;
              end else if (req_ready) begin
                scl_low <= 1'b1;
                req_fire <= 1'b1;
                req_data <= {1'b1, cmd_reg, 3'h0, 32'h00000000};
                link_state <= LINK_WAIT;
              end else begin
                link_state <= LINK_IDLE;
              end
            end
          end
          LINK_WAIT: begin
            if (rsp_valid) begin
              rsp_buf <= rsp_word[31:0];
              rsp_len <= rsp_word[34:32];
              rsp_idx <= 3'h1;
              tx_sh <= first_byte;
              sda_low <= ~first_byte[7];
              scl_low <= 1'b0;
              bit_cnt <= 4'h0;
              link_state <= LINK_TX;
            end
          end
          LINK_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                sda_low <= 1'b0;
                link_state <= LINK_TX_ACK;
              end else begin
                tx_sh <= {tx_sh[6:0], 1'b0};
                sda_low <= ~tx_sh[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          LINK_TX_ACK: begin
            if (scl_rise) begin
              tx_acked <= ~sda_s;
            end else if (scl_fall) begin
              if (tx_acked) begin
                tx_sh <= next_byte;
                sda_low <= ~next_byte[7];
                rsp_idx <= rsp_idx + 3'h1;
                bit_cnt <= 4'h0;
                link_state <= LINK_TX;
              end else begin
                link_state <= LINK_IDLE;
              end
            end
          end
          default: begin
            link_state <= LINK_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain pins: the driven level is always low.
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe_n = ~sda_low;
  assign scl_oe_n = ~scl_low;

  // ----------------------------------------------------------------------
  // Crossings between link and core
  // ----------------------------------------------------------------------
  logic core_req_valid;
  logic [REQ_W-1:0] core_req;
  logic core_rsp_fire;
  logic [RSP_W-1:0] core_rsp;
  logic core_rsp_ready;

  ticb_xfer #(.W(REQ_W)) u_req_xfer (
    .src_clk(link_clk),
    .src_rst_n(link_rst_n),
    .src_valid(req_fire),
    .src_data(req_data),
    .src_ready(req_ready),
    .dst_clk(clk),
    .dst_rst_n(rst_n),
    .dst_valid(core_req_valid),
    .dst_data(core_req)
  );

  ticb_xfer #(.W(RSP_W)) u_rsp_xfer (
    .src_clk(clk),
    .src_rst_n(rst_n),
    .src_valid(core_rsp_fire),
    .src_data(core_rsp),
    .src_ready(core_rsp_ready),
    .dst_clk(link_clk),
    .dst_rst_n(link_rst_n),
    .dst_valid(rsp_valid),
    .dst_data(rsp_word)
  );

  // ----------------------------------------------------------------------
  // Core domain: request decode
  // ----------------------------------------------------------------------
  logic c_rd;
  logic [7:0] c_cmd;
  logic [2:0] c_cnt;
  logic [31:0] c_data;
  logic c_write;
  logic c_read_only;
  logic ivc_event;
  logic id_write;

  assign {c_rd, c_cmd, c_cnt, c_data} = core_req;
  assign c_write = core_req_valid && !c_rd;
  assign c_read_only = (c_cmd == CMD_CURRENT) || (c_cmd == CMD_TEMPERATURE) ||
                       (c_cmd == CMD_REVISION);
  // Unknown codes are refused the same way as read-only ones.
  assign ivc_event = c_write && (c_read_only || !((c_cmd == CMD_PHASE) ||
                     (c_cmd == CMD_STATUS_BYTE) || (c_cmd == CMD_STATUS_CML) ||
                     (c_cmd == CMD_MAKER_ID)));
  assign id_write = c_write && (c_cmd == CMD_MAKER_ID) && (c_cnt == ID_WRITE_BYTES) &&
                    (c_data[2:0] == ID_COUNT) && (c_data[7:3] == 5'h00);

  // ----------------------------------------------------------------------
  // Core domain: telemetry samples
  // ----------------------------------------------------------------------
  logic signed [MAN_W-1:0] cur_smp [NUM_PHASES];
  logic signed [MAN_W-1:0] temp_smp [NUM_PHASES];
  logic signed [MAN_W-1:0] cur_in [NUM_PHASES];
  logic signed [MAN_W-1:0] temp_in [NUM_PHASES];
  logic [7:0] phase_sel;

  assign cur_in[0] = phase0_current;
  assign cur_in[1] = phase1_current;
  assign temp_in[0] = phase0_temperature;
  assign temp_in[1] = phase1_temperature;

  // All phases load on the same strobe, so a read sees one coherent set.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_PHASES; i++) begin
        cur_smp[i] <= '0;
        temp_smp[i] <= '0;
      end
    end else if (sample_strobe) begin
      for (int i = 0; i < NUM_PHASES; i++) begin
        if (cur_in[i] > CUR_MAN_MAX) begin
          cur_smp[i] <= CUR_MAN_MAX;
        end else if (cur_in[i] < CUR_MAN_MIN) begin
          cur_smp[i] <= CUR_MAN_MIN;
        end else begin
          cur_smp[i] <= cur_in[i];
        end
        temp_smp[i] <= temp_in[i];
      end
    end
  end

  logic signed [12:0] cur_sum;
  logic signed [MAN_W-1:0] temp_hot;
  logic [15:0] cur_word;
  logic [15:0] temp_word;

  // Stack totals are summed and rescaled; a single phase passes straight.
  assign cur_sum = 13'(cur_smp[0]) + 13'(cur_smp[1]);
  assign temp_hot = (temp_smp[1] > temp_smp[0]) ? temp_smp[1] : temp_smp[0];
  assign cur_word = (phase_sel == PHASE_ALL) ? lin_word(cur_sum, CUR_EXP) :
                    lin_word(13'(cur_smp[phase_sel[0]]), CUR_EXP);
  assign temp_word = (phase_sel == PHASE_ALL) ? {TEMP_EXP, temp_hot} :
                     {TEMP_EXP, temp_smp[phase_sel[0]]};

  // ----------------------------------------------------------------------
  // Core domain: phase, identity and status registers
  // ----------------------------------------------------------------------
  logic [ID_W-1:0] maker_id;
  logic id_loaded;
  logic cml_summary;
  logic cml_invalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_sel <= PHASE_RESET;
    end else if (c_write && c_cmd == CMD_PHASE && c_cnt != 3'h0) begin
      phase_sel <= c_data[7:0];
    end
  end

  // The store restarts from the saved copy one cycle after reset release.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      maker_id <= ID_RESET;
      id_loaded <= 1'b0;
      nvm_save <= 1'b0;
      nvm_save_data <= ID_RESET;
    end else begin
      id_loaded <= 1'b1;
      nvm_save <= id_write;
      if (!id_loaded) begin
        maker_id <= nvm_id_value;
      end else if (id_write) begin
        maker_id <= c_data[31:8];
        nvm_save_data <= c_data[31:8];
      end
    end
  end

  // A new fault in the same cycle as a clearing write still lands.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cml_summary <= 1'b0;
      cml_invalid <= 1'b0;
    end else begin
      cml_summary <= (cml_summary & ~(c_write && c_cmd == CMD_STATUS_BYTE && c_cnt != 3'h0 &&
                     c_data[STATUS_CML_SUMMARY_BIT])) | ivc_event;
      cml_invalid <= (cml_invalid & ~(c_write && c_cmd == CMD_STATUS_CML && c_cnt != 3'h0 &&
                     c_data[CML_INVALID_CMD_BIT])) | ivc_event;
    end
  end

  // Alert stays low while a fault is recorded, released once all are cleared.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alert_oe_n <= 1'b1;
    end else begin
      alert_oe_n <= ~(cml_summary | cml_invalid);
    end
  end

  assign alert_out = 1'b0;

  // ----------------------------------------------------------------------
  // Core domain: read answers
  // ----------------------------------------------------------------------
  logic [RSP_W-1:0] next_rsp;

  // Words go low byte first; a block read leads with its byte count.
  always_comb begin
    next_rsp = {3'h0, 32'h00000000};
    case (c_cmd)
      CMD_CURRENT: next_rsp = {3'h2, 16'h0000, cur_word};
      CMD_TEMPERATURE: next_rsp = {3'h2, 16'h0000, temp_word};
      CMD_REVISION: next_rsp = {3'h1, 24'h000000, PART_ONE_LEVEL, PART_TWO_LEVEL};
      CMD_MAKER_ID: next_rsp = {3'h4, maker_id, 5'h00, ID_COUNT};
      CMD_PHASE: next_rsp = {3'h1, 24'h000000, phase_sel};
      CMD_STATUS_BYTE: next_rsp = {3'h1, 30'h00000000, cml_summary, 1'b0};
      CMD_STATUS_CML: next_rsp = {3'h1, 24'h000000, cml_invalid, 7'h00};
      default: next_rsp = {3'h0, 32'h00000000};
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_rsp_fire <= 1'b0;
      core_rsp <= '0;
    end else begin
      core_rsp_fire <= core_req_valid && c_rd && core_rsp_ready;
      if (core_req_valid && c_rd) begin
        core_rsp <= next_rsp;
      end
    end
  end
endmodule : ticb_top
`default_nettype wire

// ---- rtl/ticb_pkg.sv ----
// Shared constants and types of the telemetry and identity command bank.
// Assumes a two-phase stack, linear telemetry words and a byte-wide command link.
`default_nettype none
package ticb_pkg;
  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_PHASE = 8'h04;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_CML = 8'h7E;
  localparam logic [7:0] CMD_CURRENT = 8'h8C;
  localparam logic [7:0] CMD_TEMPERATURE = 8'h8D;
  localparam logic [7:0] CMD_REVISION = 8'h98;
  localparam logic [7:0] CMD_MAKER_ID = 8'h99;

  // ----------------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] PHASE_ALL = 8'hFF;
  localparam logic [7:0] PHASE_RESET = 8'hFF;
  localparam int STATUS_CML_SUMMARY_BIT = 1;
  localparam int CML_INVALID_CMD_BIT = 7;
  localparam int NUM_PHASES = 2;
  localparam int MAN_W = 11;
  localparam int EXP_W = 5;
  localparam int ID_W = 24;
  localparam logic [2:0] ID_COUNT = 3'h3;
  localparam logic [2:0] ID_WRITE_BYTES = 3'h4;
  localparam logic [ID_W-1:0] ID_RESET = 24'h000000;
  // Current mantissa LSB is 0.25 A; clamp limits are -15 A and 90 A.
  localparam logic [EXP_W-1:0] CUR_EXP = 5'h1E;
  localparam logic signed [MAN_W-1:0] CUR_MAN_MIN = 11'h7C4;
  localparam logic signed [MAN_W-1:0] CUR_MAN_MAX = 11'h168;
  // Temperature mantissa LSB is one degree.
  localparam logic [EXP_W-1:0] TEMP_EXP = 5'h00;
  // Compliance nibbles: arbitrary neutral values.
  localparam logic [3:0] PART_ONE_LEVEL = 4'h1;
  localparam logic [3:0] PART_TWO_LEVEL = 4'h1;
  localparam logic [6:0] BUS_ADDRESS = 7'h24;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] MAX_WRITE_BYTES = 3'h4;
  localparam int REQ_W = 44;
  localparam int RSP_W = 35;
  // ----------------------------------------------------------------------
  // Link engine states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    LINK_IDLE = 3'b000,
    LINK_RX = 3'b001,
    LINK_RX_ACK = 3'b010,
    LINK_WAIT = 3'b011,
    LINK_TX = 3'b100,
    LINK_TX_ACK = 3'b101
  } ticb_link_state_t;

endpackage : ticb_pkg
`default_nettype wire

// ---- rtl/ticb_sync.sv ----
// Two-flop level synchroniser.
// Assumes d is a level from another clock domain or a pin.
`timescale 1ns/1ns
`default_nettype none
module ticb_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta;

  // The first stage feeds only the second stage, giving it a cycle to settle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : ticb_sync
`default_nettype wire

// ---- rtl/ticb_xfer.sv ----
// Toggle handshake that carries one word between two clock domains.
// Assumes the source offers a new word only while src_ready is high.
`timescale 1ns/1ns
`default_nettype none
module ticb_xfer #(
  parameter int W = 8
) (
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_valid,
  input wire logic [W-1:0] src_data,
  output logic src_ready,
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic dst_valid,
  output logic [W-1:0] dst_data
);
  logic req_tgl;
  logic ack_tgl;
  logic req_s;
  logic ack_s;
  logic req_seen;
  logic [W-1:0] hold;

  ticb_sync u_req_sync (.clk(dst_clk), .rst_n(dst_rst_n), .d(req_tgl), .q(req_s));
  ticb_sync u_ack_sync (.clk(src_clk), .rst_n(src_rst_n), .d(ack_tgl), .q(ack_s));

  // The held word stays still until the far side has answered the toggle.
  assign src_ready = (req_tgl == ack_s);

  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      req_tgl <= 1'b0;
      hold <= '0;
    end else if (src_valid && src_ready) begin
      req_tgl <= ~req_tgl;
      hold <= src_data;
    end
  end

  // A change of the synchronised toggle marks one new word.
  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      dst_valid <= 1'b0;
      dst_data <= '0;
    end else begin
      req_seen <= req_s;
      ack_tgl <= req_s;
      dst_valid <= (req_s != req_seen);
      if (req_s != req_seen) begin
        dst_data <= hold;
      end
    end
  end
endmodule : ticb_xfer
`default_nettype wire

// ---- tb/ticb_asserts.sv ----
// Pin-level checks of the command bank, bound to its top module.
// Assumes only the top module's ports are visible here.
`timescale 1ns/1ns
`default_nettype none
module ticb_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic alert_out,
  input wire logic alert_oe_n,
  input wire logic nvm_save,
  input wire logic [ticb_pkg::ID_W-1:0] nvm_save_data
);
  import ticb_pkg::*;
  // Everything is judged on the core clock; link pins are slow enough for that.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  open_drain_a: assert property (!(scl_out | sda_out | alert_out))
    else $error("open-drain level not low");
  alert_hold_a: assert property ($fell(alert_oe_n) |=> !alert_oe_n [*2])
    else $error("alert dropped too soon");
  fault_idle_a: assert property ($fell(alert_oe_n) |-> scl_in && sda_in)
    else $error("fault raised inside a frame");
  clear_idle_a: assert property ($rose(alert_oe_n) |-> scl_in && sda_in)
    else $error("fault cleared inside a frame");
  save_idle_a: assert property (nvm_save |-> scl_in && sda_in)
    else $error("identity saved inside a frame");
  save_pulse_a: assert property (nvm_save |=> !nvm_save)
    else $error("save pulse too long");
  save_data_a: assert property (!$stable(nvm_save_data) |-> nvm_save)
    else $error("saved identity moved without a save");
  stretch_max_a: assert property ($fell(scl_oe_n) |-> ##[1:100] scl_oe_n)
    else $error("clock stretch too long");
  stretch_min_a: assert property ($fell(scl_oe_n) |=> !scl_oe_n [*2])
    else $error("clock stretch too short");
endmodule : ticb_asserts
bind ticb_top ticb_asserts u_ticb_asserts (.*);
`default_nettype wire

// ---- tb/ticb_host.sv ----
// Host model of the two-wire link; open-drain releases, moved on the core clock.
// Assumes the bench ANDs all releases into each wire, as a pull-up bus does.
`timescale 1ns/1ns
`default_nettype none
module ticb_host (
  input wire logic clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_rel,
  output logic sda_rel
);
  // The bus idles high before the first frame.
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  // Six cycles a phase keep SCL low longer than the link needs to see it.
  task automatic tick();
    repeat (6) @(posedge clk);
  endtask : tick
  // One bit; the wait bounds a stretch so a stuck clock cannot hang us.
  task automatic bitx(input logic b, output logic r);
    sda_rel <= b;
    tick();
    scl_rel <= 1'b1;
    for (int i = 0; i < 400 && scl_in !== 1'b1; i++) @(posedge clk);
    tick();
    r = sda_in;
    scl_rel <= 1'b0;
    tick();
  endtask : bitx
  // A byte, most significant bit first, then the acknowledge slot.
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
                       output logic r);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, r);
  endtask : xbyte
  task automatic start();
    sda_rel <= 1'b1;
    tick();
    scl_rel <= 1'b1;
    tick();
    sda_rel <= 1'b0;
    tick();
    scl_rel <= 1'b0;
    tick();
  endtask : start
  // The idle gap lets the core finish the request before the next frame.
  task automatic stop();
    sda_rel <= 1'b0;
    tick();
    scl_rel <= 1'b1;
    tick();
    sda_rel <= 1'b1;
    repeat (60) @(posedge clk);
  endtask : stop
endmodule : ticb_host
`default_nettype wire

// ---- tb/ticb_top_tb.sv ----
// Bench for the command bank: link frames from the host model, samples by strobe.
// Assumes the host model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module ticb_top_tb;
  import ticb_pkg::*;
  logic clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, sample_strobe = 1'b0, saved = 1'b0;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, alert_oe_n, nvm_save, scl_rel, sda_rel;
  logic [MAN_W-1:0] phase0_current = '0, phase1_current = '0;
  logic [MAN_W-1:0] phase0_temperature = '0, phase1_temperature = '0;
  logic [ID_W-1:0] nvm_id_value = 24'h5A3C96;
  logic [ID_W-1:0] nvm_save_data;
  logic [31:0] q;
  wire logic scl_in = scl_rel & scl_oe_n;
  wire logic sda_in = sda_rel & sda_oe_n;
  int errors = 0, n_compared = 0, cyc = 0;
  initial forever #10 clk = ~clk;
  initial #1 forever #6 link_clk = ~link_clk; // Offset keeps link edges off clk edges.
  ticb_top u_ticb_top (.scl_out(), .sda_out(), .alert_out(), .*);
  ticb_host u_ticb_host (.*);
  // Latch the save pulse and cut a hung run short.
  always @(posedge clk) begin
    saved <= saved | (nvm_save === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] cmd, input int n, input logic [31:0] d);
    logic [7:0] b;
    logic a;
    u_ticb_host.start();
    u_ticb_host.xbyte({BUS_ADDRESS, 1'b0}, 1'b1, b, a);
    u_ticb_host.xbyte(cmd, 1'b1, b, a);
    for (int i = 0; i < n; i++) u_ticb_host.xbyte(d[8*i+:8], 1'b1, b, a);
    u_ticb_host.stop();
  endtask : wr
  // Bytes come low first; the last one is refused to end the read.
  task automatic rd(input logic [7:0] cmd, input int n, output logic [31:0] r);
    logic [7:0] b;
    logic a;
    r = '0;
    u_ticb_host.start();
    u_ticb_host.xbyte({BUS_ADDRESS, 1'b0}, 1'b1, b, a);
    u_ticb_host.xbyte(cmd, 1'b1, b, a);
    u_ticb_host.start();
    u_ticb_host.xbyte({BUS_ADDRESS, 1'b1}, 1'b1, b, a);
    for (int i = 0; i < n; i++) begin
      u_ticb_host.xbyte(8'hFF, i == n - 1, b, a);
      r[8*i+:8] = b;
    end
    u_ticb_host.stop();
  endtask : rd
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  // Phase 0 is clamped up to -15 A, phase 1 down to 90 A; the stack sums both.
  initial begin
    static logic [7:0] ph [3] = '{8'hFF, 8'h00, 8'h01};
    static logic [7:0] bad [4] = '{CMD_CURRENT, CMD_TEMPERATURE, CMD_REVISION, 8'h9A};
    static logic [10:0] ci [3] = '{11'h12C, 11'h7C4, 11'h168};
    static logic [10:0] ti [3] = '{11'h046, 11'h032, 11'h046};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    rd(CMD_MAKER_ID, 4, q);
    chk(q, {nvm_id_value, 8'h03});
    rd(CMD_REVISION, 1, q);
    chk(q, {24'h0, PART_ONE_LEVEL, PART_TWO_LEVEL});
    $display("test reset values done");
    phase0_current <= 11'h79C;
    phase1_current <= 11'h190;
    phase0_temperature <= 11'h032;
    phase1_temperature <= 11'h046;
    sample_strobe <= 1'b1;
    @(posedge clk);
    sample_strobe <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      wr(CMD_PHASE, 1, {24'h0, ph[i]});
      rd(CMD_CURRENT, 2, q);
      chk(q, {16'h0, CUR_EXP, ci[i]});
      rd(CMD_TEMPERATURE, 2, q);
      chk(q, {16'h0, TEMP_EXP, ti[i]});
    end
    $display("test telemetry done");
    for (int i = 0; i < 4; i++) begin
      wr(bad[i], 2, 32'h0000A55A);
      rd(CMD_STATUS_BYTE, 1, q);
      chk(q, 32'h02);
      rd(CMD_STATUS_CML, 1, q);
      chk(q, 32'h80);
      chk({31'h0, alert_oe_n}, 32'h0);
      wr(CMD_STATUS_CML, 1, 32'h80);
      wr(CMD_STATUS_BYTE, 1, 32'h02);
      chk({31'h0, alert_oe_n}, 32'h1);
    end
    rd(CMD_CURRENT, 2, q);
    chk(q, {16'h0, CUR_EXP, 11'h168});
    $display("test faults done");
    wr(CMD_MAKER_ID, 4, 32'hCCBBAA02);
    rd(CMD_MAKER_ID, 4, q);
    chk({q[31:1], saved}, {nvm_id_value, 8'h02});
    wr(CMD_MAKER_ID, 4, 32'hCCBBAA03);
    chk({7'h0, saved, nvm_save_data}, {8'h01, 24'hCCBBAA});
    rd(CMD_MAKER_ID, 4, q);
    chk(q, 32'hCCBBAA03);
    rst_n <= 1'b0;
    nvm_id_value <= 24'h1E2D4B;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    rd(CMD_MAKER_ID, 4, q);
    chk(q, 32'h1E2D4B03);
    $display("test identity done");
    conclude();
  end
endmodule : ticb_top_tb
`default_nettype wire
